// >>> include/boost_seq_regs.svh
// Purpose: Timing counts and level thresholds for the boost startup sequencer.
// Assumes: CLK runs at 40 MHz.
// Notes:   Times keep their printed figure; cycle counts are derived from them.
`ifndef BOOST_SEQ_REGS_SVH
`define BOOST_SEQ_REGS_SVH

`define CLK_MHZ           40
`define US_NS             1000
`define US_CYC            ((`US_NS * `CLK_MHZ) / 1000)
`define OSC_MAX_HZ        3500000
`define OSC_MIN_PERIOD_CYC ((`CLK_MHZ * 1000000 + `OSC_MAX_HZ - 1) / `OSC_MAX_HZ)
`define OSC_MIN_HALF_CYC  (`OSC_MIN_PERIOD_CYC / 2)
`define SYNC_LOSS_NS      5000
`define SYNC_LOSS_CYC     ((`SYNC_LOSS_NS * `CLK_MHZ) / 1000)
`define PIN_STUCK_NS      10000
`define PIN_STUCK_CYC     ((`PIN_STUCK_NS * `CLK_MHZ) / 1000)
`define REPEAT_LOW_NS     150
`define REPEAT_LOW_CYC    ((`REPEAT_LOW_NS * `CLK_MHZ + 999) / 1000)
`define LATCH_CLR_MS      16
`define LATCH_CLR_US      (`LATCH_CLR_MS * 1000)
`define DETECT_US         1500
`define SOFT_START_MS     8
`define SOFT_START_US     (`SOFT_START_MS * 1000)
`define UV_DIVISOR        12
`define SS_DONE_PCT       93
`define CH_COUNT          4

`endif

// >>> include/boost_seq_pkg.sv
// Purpose: Types shared by the boost startup sequencer.
// Assumes: Nothing beyond SystemVerilog.
// Notes:   State codes are fixed so waveforms read the same in every tool.
package boost_seq_pkg;

  typedef enum logic [2:0] {
    ST_OFF        = 3'h0,
    ST_GATE       = 3'h1,
    ST_WAIT_DIM   = 3'h2,
    ST_DETECT     = 3'h3,
    ST_SOFT_START = 3'h4,
    ST_RUN        = 3'h5,
    ST_LATCHED    = 3'h6,
    ST_FREQ_FAULT = 3'h7
  } seq_state_t;

endpackage

// >>> hdl/boost_startup_and_clock_sequencer.sv
// Purpose: Startup order, fault latch and switching-clock selection of a boost LED driver.
// Assumes: Analog comparators arrive as pins; the output and level codes come from
//          a converter clocked by CLK.
// Notes:   CE low freezes every flip-flop; state-driven outputs are registered from the next state, so they change with the state.
`include "boost_seq_regs.svh"

// Functional notes
// R1: Before soft start, output must exceed one twelfth of the overvoltage level.
// R2: Output undervoltage shuts down at once and latches off until cleared.
// R3: Wake low over 16 ms or supply lockout clears the latched fault.
// R4: Dim low over 16 ms with wake high clears the latch; clock keeps running.
// R5: Soft start ends on channels in regulation, 93% output, or timer expiry.
// R6: Startup order: checks, disconnect driver, pin detection, soft start.
// R7: Wake high powers supply, enables clock repeat, starts disconnect pull-down.
// R8: Disconnect at target enables current reference, then waits for dim high.
// R9: On first dim high each sink pin is classed in use, disabled or shorted.
// R10: Soft start follows a 1.5 ms detect phase and lasts up to 8 ms.
// R11: Internal oscillator is clamped to at most 3.5 MHz.
// R12: A shorted frequency pin shuts the device down; here it only stops switching, flags error and restarts soft start.
// R13: No start while frequency pin is low, until released or sync seen.
// R14: Host keeps sync high and low times each at least 150 ns.
// R15: Host keeps sync duty inside the band for its frequency.
// R16: Host switches clock source 500 ns after dim rise or while dim low.
// R17: Sync lost to open pin falls back to internal oscillator after 5 us, no error.
// R18: Sync stuck low flags error after 10 us, stops switching, restarts soft start.
// R19: No dithering while running from an external sync clock.
// R20: Clock repeat runs whenever wake is high, at the oscillator rate.
// R21: Clock repeat is 50% internally, a 150 ns low pulse per sync cycle.
// R22: A shorted sink pin flags error and holds off soft start while retrying.
// R23: Error flag is released when the detect phase ends; here it is released once no sink pin is shorted, still inside detect.
// R24: Intervals come from a microsecond tick; sync is judged by edges in a window. Here sync loss and stuck pin count CLK cycles.
module boost_startup_and_clock_sequencer #(
  parameter int LATCH_CLR_US  = `LATCH_CLR_US,
  parameter int SOFT_START_US = `SOFT_START_US,
  parameter int DETECT_US     = `DETECT_US
) (
  // Clock, reset and enable
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       CE,
  // Host-driven pins
  input  wire logic       WAKE,
  input  wire logic       DIM,
  input  wire logic       FREQ_PIN,
  input  wire logic       FREQ_PIN_RELEASED,
  // Analog comparator pins
  input  wire logic       SUPPLY_LOW,
  input  wire logic       GATE_AT_TARGET,
  input  wire logic       FREQ_RISE_FAULT,
  input  wire logic       SPREAD_FITTED,
  input  wire logic [3:0] CH_SHORT,
  input  wire logic [3:0] CH_UNUSED,
  input  wire logic [3:0] CH_IN_REG,
  // Converter codes on CLK
  input  wire logic [9:0] OUT_SENSE_CODE,
  input  wire logic [9:0] OVP_LEVEL_CODE,
  input  wire logic [7:0] OSC_HALF_PERIOD,
  // Power stage controls
  output logic            SUPPLY_ON,
  output logic            GATE_PULL_DOWN,
  output logic            CURRENT_REF_EN,
  output logic            DETECT_ACTIVE,
  output logic            SOFT_START,
  output logic            SWITCH_EN,
  output logic [3:0]      CH_ENABLED,
  // Clock status
  output logic            SYNC_MODE,
  output logic            DITHER_EN,
  output logic            OSC_CLAMPED,
  output logic            CLOCK_REPEAT,
  // Fault status
  output logic            ERROR_N,
  output logic            LATCHED_OFF
);

  localparam int NSYNC = 20;

  logic [NSYNC-1:0]         meta_reg;
  logic [NSYNC-1:0]         pin_reg;
  logic                     wake;
  logic                     dim;
  logic                     fpin;
  logic                     fpin_rel;
  logic                     supply_low;
  logic                     gate_ok;
  logic                     rise_fault;
  logic                     spread;
  logic [3:0]               ch_short;
  logic [3:0]               ch_unused;
  logic [3:0]               ch_in_reg;
  logic [5:0]               pre_reg;
  logic                     us_tick;
  logic [7:0]               half_eff;
  logic [7:0]               osc_cnt_reg;
  logic                     osc_reg;
  logic                     fpin_d_reg;
  logic                     sync_edge;
  logic [8:0]               gap_reg;
  logic                     sync_mode_reg;
  logic [8:0]               low_cnt_reg;
  logic                     freq_short;
  logic                     start_ok;
  logic [2:0]               pulse_reg;
  boost_seq_pkg::seq_state_t state_reg;
  boost_seq_pkg::seq_state_t state_next;
  logic [13:0]              tmr_reg;
  logic                     retry;
  logic                     detect_done;
  logic                     above_low;
  logic                     at_93;
  logic                     ss_done;
  logic [3:0]               ch_en_reg;
  logic [13:0]              wake_low_reg;
  logic [13:0]              dim_low_reg;
  logic                     latch_reg;
  logic                     latch_set;
  logic                     latch_clr;
  logic                     active;

  // Every pin passes two flip-flops; the first stage feeds only the second.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      meta_reg <= '0;
      pin_reg  <= '0;
    end else if (CE) begin
      meta_reg <= {WAKE, DIM, FREQ_PIN, FREQ_PIN_RELEASED, SUPPLY_LOW, GATE_AT_TARGET,
                   FREQ_RISE_FAULT, SPREAD_FITTED, CH_SHORT, CH_UNUSED, CH_IN_REG};
      pin_reg  <= meta_reg;
    end
  end

  assign wake       = pin_reg[19];
  assign dim        = pin_reg[18];
  assign fpin       = pin_reg[17];
  assign fpin_rel   = pin_reg[16];
  assign supply_low = pin_reg[15];
  assign gate_ok    = pin_reg[14];
  assign rise_fault = pin_reg[13];
  assign spread     = pin_reg[12];
  assign ch_short   = pin_reg[11:8];
  assign ch_unused  = pin_reg[7:4];
  assign ch_in_reg  = pin_reg[3:0];

  // A single microsecond tick paces the detect, soft-start and latch-clear intervals.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pre_reg <= 6'h00;
    end else if (CE) begin
      pre_reg <= us_tick ? 6'h00 : pre_reg + 6'h01; // R24
    end
  end

  assign us_tick = (pre_reg == 6'(`US_CYC - 1));

  // The clamp is applied always, so a failing frequency resistor cannot speed it up.
  assign half_eff = (OSC_HALF_PERIOD < 8'(`OSC_MIN_HALF_CYC)) ?
                    8'(`OSC_MIN_HALF_CYC) : OSC_HALF_PERIOD; // R11

  always_ff @(posedge CLK) begin
    if (RESET) begin
      osc_cnt_reg <= 8'h00;
      osc_reg     <= 1'b0;
    end else if (CE) begin
      if (!wake) begin
        osc_cnt_reg <= 8'h00;
        osc_reg     <= 1'b0;
      end else if (osc_cnt_reg >= half_eff - 8'h01) begin
        osc_cnt_reg <= 8'h00;
        osc_reg     <= ~osc_reg; // R20
      end else begin
        osc_cnt_reg <= osc_cnt_reg + 8'h01;
      end
    end
  end

  assign sync_edge = fpin & ~fpin_d_reg;

  // Sync is present while rising edges keep arriving inside the loss window.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      fpin_d_reg    <= 1'b0;
      gap_reg       <= 9'h000;
      sync_mode_reg <= 1'b0;
    end else if (CE) begin
      fpin_d_reg <= fpin;
      if (sync_edge) begin
        gap_reg       <= 9'h000;
        sync_mode_reg <= 1'b1; // R24
      end else if (gap_reg == 9'(`SYNC_LOSS_CYC)) begin
        sync_mode_reg <= 1'b0; // R17
      end else begin
        gap_reg <= gap_reg + 9'h001;
      end
    end
  end

  // An open pin floats up to its released level, so only a low, unreleased pin counts.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      low_cnt_reg <= 9'h000;
    end else if (CE) begin
      if (fpin || fpin_rel) begin
        low_cnt_reg <= 9'h000;
      end else if (!freq_short) begin
        low_cnt_reg <= low_cnt_reg + 9'h001;
      end
    end
  end

  assign freq_short = (low_cnt_reg == 9'(`PIN_STUCK_CYC)); // R18
  assign start_ok   = (fpin_rel || sync_mode_reg) && !freq_short; // R13

  // Under sync each rising edge starts a fixed low pulse, independent of sync rate.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      pulse_reg <= 3'h0;
    end else if (CE) begin
      if (sync_edge && sync_mode_reg) begin
        pulse_reg <= 3'(`REPEAT_LOW_CYC); // R21
      end else if (pulse_reg != 3'h0) begin
        pulse_reg <= pulse_reg - 3'h1;
      end
    end
  end

  assign above_low   = ({4'h0, OUT_SENSE_CODE} * 14'(`UV_DIVISOR)) >
                       {4'h0, OVP_LEVEL_CODE}; // R1
  assign at_93       = ({7'h00, OUT_SENSE_CODE} * 17'd100) >=
                       ({7'h00, OVP_LEVEL_CODE} * 17'(`SS_DONE_PCT));
  assign detect_done = (tmr_reg >= 14'(DETECT_US)); // R10
  assign ss_done     = (&(ch_in_reg | ~ch_en_reg)) || at_93 ||
                       (tmr_reg >= 14'(SOFT_START_US)); // R5
  assign retry       = (state_reg == boost_seq_pkg::ST_DETECT) && detect_done &&
                       (|ch_short); // R22
  assign active      = (state_reg != boost_seq_pkg::ST_OFF) &&
                       (state_reg != boost_seq_pkg::ST_GATE);

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      boost_seq_pkg::ST_OFF: begin
        if (!latch_reg && start_ok) begin
          state_next = boost_seq_pkg::ST_GATE; // R7
        end
      end
      boost_seq_pkg::ST_GATE: begin
        if (gate_ok && start_ok) begin
          state_next = boost_seq_pkg::ST_WAIT_DIM; // R8
        end
      end
      boost_seq_pkg::ST_WAIT_DIM: begin
        if (dim) begin
          state_next = boost_seq_pkg::ST_DETECT; // R9
        end
      end
      boost_seq_pkg::ST_DETECT: begin
        if (detect_done && !(|ch_short)) begin
          state_next = above_low ? boost_seq_pkg::ST_SOFT_START
                                 : boost_seq_pkg::ST_LATCHED; // R6
        end
      end
      boost_seq_pkg::ST_SOFT_START: begin
        if (ss_done) begin
          state_next = boost_seq_pkg::ST_RUN; // R5
        end
      end
      boost_seq_pkg::ST_RUN: begin
        state_next = boost_seq_pkg::ST_RUN;
      end
      boost_seq_pkg::ST_LATCHED: begin
        if (!latch_reg) begin
          state_next = boost_seq_pkg::ST_OFF; // R4
        end
      end
      boost_seq_pkg::ST_FREQ_FAULT: begin
        if (start_ok) begin
          state_next = boost_seq_pkg::ST_SOFT_START; // R18
        end
      end
    endcase
    if (active && freq_short && state_reg != boost_seq_pkg::ST_LATCHED) begin
      state_next = boost_seq_pkg::ST_FREQ_FAULT; // R12
    end
    if (!wake || supply_low) begin
      state_next = boost_seq_pkg::ST_OFF;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      state_reg <= boost_seq_pkg::ST_OFF;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  // The phase timer restarts on every state change and on each detect retry.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tmr_reg <= 14'h0000;
    end else if (CE) begin
      if (state_next != state_reg || retry) begin
        tmr_reg <= 14'h0000; // R22
      end else if (us_tick && tmr_reg != 14'h3fff) begin
        tmr_reg <= tmr_reg + 14'h0001;
      end
    end
  end

  // Channel classes are frozen when the detect phase passes.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ch_en_reg <= 4'h0;
    end else if (CE) begin
      if (state_reg == boost_seq_pkg::ST_DETECT && detect_done && !(|ch_short)) begin
        ch_en_reg <= ~ch_unused; // R9
      end else if (state_next == boost_seq_pkg::ST_OFF) begin
        ch_en_reg <= 4'h0;
      end
    end
  end

  // Low-level timers count one past the limit so the clear means strictly longer.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      wake_low_reg <= 14'h0000;
      dim_low_reg  <= 14'h0000;
    end else if (CE) begin
      if (wake) begin
        wake_low_reg <= 14'h0000;
      end else if (us_tick && wake_low_reg <= 14'(LATCH_CLR_US)) begin
        wake_low_reg <= wake_low_reg + 14'h0001; // R3
      end
      if (dim || !wake) begin
        dim_low_reg <= 14'h0000;
      end else if (us_tick && dim_low_reg <= 14'(LATCH_CLR_US)) begin
        dim_low_reg <= dim_low_reg + 14'h0001; // R4
      end
    end
  end

  assign latch_set = (state_reg == boost_seq_pkg::ST_DETECT) &&
                     (state_next == boost_seq_pkg::ST_LATCHED); // R2
  assign latch_clr = supply_low || (wake_low_reg > 14'(LATCH_CLR_US)) ||
                     (dim_low_reg > 14'(LATCH_CLR_US)); // R3

  // A new fault in the clearing cycle wins, so it is never lost.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      latch_reg <= 1'b0;
    end else if (CE) begin
      if (latch_set) begin
        latch_reg <= 1'b1; // R2
      end else if (latch_clr) begin
        latch_reg <= 1'b0; // R3
      end
    end
  end

  // Stage controls other than SUPPLY_ON and CH_ENABLED follow the next state so they line up with the state register.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SUPPLY_ON      <= 1'b0;
      GATE_PULL_DOWN <= 1'b0;
      CURRENT_REF_EN <= 1'b0;
      DETECT_ACTIVE  <= 1'b0;
      SOFT_START     <= 1'b0;
      SWITCH_EN      <= 1'b0;
      CH_ENABLED     <= 4'h0;
      LATCHED_OFF    <= 1'b0;
      ERROR_N        <= 1'b1;
    end else if (CE) begin
      SUPPLY_ON      <= wake; // R7
      GATE_PULL_DOWN <= (state_next != boost_seq_pkg::ST_OFF) &&
                        (state_next != boost_seq_pkg::ST_LATCHED); // R7
      CURRENT_REF_EN <= (state_next == boost_seq_pkg::ST_WAIT_DIM) ||
                        (state_next == boost_seq_pkg::ST_DETECT) ||
                        (state_next == boost_seq_pkg::ST_SOFT_START) ||
                        (state_next == boost_seq_pkg::ST_RUN) ||
                        (state_next == boost_seq_pkg::ST_FREQ_FAULT); // R8
      DETECT_ACTIVE  <= (state_next == boost_seq_pkg::ST_DETECT); // R9
      SOFT_START     <= (state_next == boost_seq_pkg::ST_SOFT_START); // R10
      SWITCH_EN      <= (state_next == boost_seq_pkg::ST_SOFT_START) ||
                        (state_next == boost_seq_pkg::ST_RUN); // R18
      CH_ENABLED     <= ch_en_reg;
      LATCHED_OFF    <= latch_set || (latch_reg && !latch_clr); // R2
      ERROR_N        <= !(((state_next == boost_seq_pkg::ST_DETECT) && (|ch_short)) ||
                          (state_next == boost_seq_pkg::ST_FREQ_FAULT)); // R23
    end
  end

  // Clock outputs stay alive in every state while wake is high.
  always_ff @(posedge CLK) begin
    if (RESET) begin
      SYNC_MODE    <= 1'b0;
      DITHER_EN    <= 1'b0;
      OSC_CLAMPED  <= 1'b0;
      CLOCK_REPEAT <= 1'b0;
    end else if (CE) begin
      SYNC_MODE    <= sync_mode_reg;
      DITHER_EN    <= spread && !sync_mode_reg && wake; // R19
      OSC_CLAMPED  <= rise_fault || (OSC_HALF_PERIOD < 8'(`OSC_MIN_HALF_CYC)); // R11
      if (!wake) begin
        CLOCK_REPEAT <= 1'b0;
      end else if (sync_mode_reg) begin
        CLOCK_REPEAT <= !((sync_edge) || (pulse_reg > 3'h1)); // R21
      end else begin
        CLOCK_REPEAT <= osc_reg; // R4
      end
    end
  end

endmodule

// >>> verif/boost_host_model.sv
// Purpose: Host that drives the wake, dimming and sync pins of the sequencer.
// Assumes: CLK is the 40 MHz bench clock.
// Notes:   Sync runs 10 cycles high and 10 low, which is 2 MHz at 50% duty.
module boost_host_model (
  // Clock
  input  wire logic CLK,
  // Requests from the bench
  input  wire logic wake_req,
  input  wire logic dim_req,
  input  wire logic sync_req,
  // Pins
  output logic      wake,
  output logic      dim,
  output logic      freq_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] phase_reg;
  logic [4:0] dim_age_reg;
  logic       sync_on_reg;
  initial begin
    {wake, dim, freq_pin, sync_on_reg} = 4'h0;
    phase_reg = 5'h00;
    dim_age_reg = 5'h00;
  end
  always @(posedge CLK) begin
    wake <= wake_req;
    dim <= dim_req;
    if (!dim) dim_age_reg <= 5'h00;
    else if (dim_age_reg != 5'h1f) dim_age_reg <= dim_age_reg + 5'h01;
    // A source change in the first 500 ns after a dim rise would upset the loop.
    if (!dim || dim_age_reg >= 5'h14) sync_on_reg <= sync_req;
    phase_reg <= (phase_reg == 5'h13) ? 5'h00 : phase_reg + 5'h01;
    freq_pin <= sync_on_reg && (phase_reg < 5'h0a);
  end
endmodule

// >>> verif/boost_seq_checker.sv
// Purpose: Concurrent checks on the sequencer's ports.
// Assumes: Single CLK domain, RESET synchronous active high, CE held high.
// Notes:   Stuck-low timing is counted on the raw pins, so bounds allow for the synchroniser.
module boost_seq_checker #(
  parameter int SOFT_START_US = 8000
) (
  // Clock and reset
  input wire logic       CLK,
  input wire logic       RESET,
  // Inputs
  input wire logic       WAKE,
  input wire logic       FREQ_PIN,
  input wire logic       FREQ_PIN_RELEASED,
  input wire logic [3:0] CH_IN_REG,
  // Outputs
  input wire logic       SUPPLY_ON,
  input wire logic       GATE_PULL_DOWN,
  input wire logic       CURRENT_REF_EN,
  input wire logic       DETECT_ACTIVE,
  input wire logic       SOFT_START,
  input wire logic       SWITCH_EN,
  input wire logic [3:0] CH_ENABLED,
  input wire logic       SYNC_MODE,
  input wire logic       DITHER_EN,
  input wire logic       ERROR_N,
  input wire logic       LATCHED_OFF
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  localparam int SS_MAX = SOFT_START_US * 40 + 8;
  logic [19:0] ss_cnt;
  logic [9:0]  low_cnt;
  always_ff @(posedge CLK) begin
    if (RESET || !SOFT_START) ss_cnt <= 20'h00000;
    else ss_cnt <= ss_cnt + 20'h00001;
  end
  always_ff @(posedge CLK) begin
    if (RESET || FREQ_PIN || FREQ_PIN_RELEASED) low_cnt <= 10'h000;
    else if (low_cnt != 10'h3ff) low_cnt <= low_cnt + 10'h001;
  end
  property p_supply_on; $rose(WAKE) |-> ##[1:4] SUPPLY_ON; endproperty
  a_supply_on: assert property (p_supply_on) else $error("supply did not follow wake");
  property p_detect_order; $rose(DETECT_ACTIVE) |-> CURRENT_REF_EN && GATE_PULL_DOWN; endproperty
  a_detect_order: assert property (p_detect_order) else $error("detect out of order");
  property p_latched_idle;
    LATCHED_OFF && $past(LATCHED_OFF) |-> !SWITCH_EN && !GATE_PULL_DOWN;
  endproperty
  a_latched_idle: assert property (p_latched_idle) else $error("active while latched");
  property p_ss_in_reg;
    $rose((CH_IN_REG & CH_ENABLED) == CH_ENABLED) && SOFT_START && CH_ENABLED != 4'h0
      |-> ##[1:6] !SOFT_START;
  endproperty
  a_ss_in_reg: assert property (p_ss_in_reg) else $error("soft start ignored regulation");
  property p_ss_timer; ss_cnt <= SS_MAX; endproperty
  a_ss_timer: assert property (p_ss_timer) else $error("soft start overran timer");
  property p_no_dither_sync; SYNC_MODE && $past(SYNC_MODE) |-> !DITHER_EN; endproperty
  a_no_dither_sync: assert property (p_no_dither_sync) else $error("dither under sync");
  property p_loss_no_error; $fell(SYNC_MODE) && FREQ_PIN_RELEASED |-> ERROR_N [*4]; endproperty
  a_loss_no_error: assert property (p_loss_no_error) else $error("error on open sync");
  property p_stuck_flag;
    low_cnt == 10'h19a && $past(SWITCH_EN, 16) |-> !ERROR_N && !SWITCH_EN;
  endproperty
  a_stuck_flag: assert property (p_stuck_flag) else $error("stuck pin not flagged");
  property p_flag_not_early; $fell(ERROR_N) |-> low_cnt >= 10'h18b || DETECT_ACTIVE; endproperty
  a_flag_not_early: assert property (p_flag_not_early) else $error("error flag early");
  c_detect: cover property ($rose(DETECT_ACTIVE));
  c_sync: cover property ($rose(SYNC_MODE));
  c_stuck: cover property ($fell(ERROR_N) && !DETECT_ACTIVE);
  c_latched: cover property ($rose(LATCHED_OFF));
endmodule

bind boost_startup_and_clock_sequencer boost_seq_checker #(.SOFT_START_US(SOFT_START_US)) chk (
  .CLK, .RESET, .WAKE, .FREQ_PIN, .FREQ_PIN_RELEASED, .CH_IN_REG, .SUPPLY_ON, .GATE_PULL_DOWN,
  .CURRENT_REF_EN, .DETECT_ACTIVE, .SOFT_START, .SWITCH_EN, .CH_ENABLED, .SYNC_MODE,
  .DITHER_EN, .ERROR_N, .LATCHED_OFF
);

// >>> verif/testbench.sv
// Purpose: Self-checking bench for the boost startup sequencer.
// Assumes: CLK at 40 MHz; short soft-start count; oscillator half period of 10 cycles.
// Notes:   Detect, soft-start and latch-clear times are shortened to 20 us each.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       CLK, RESET, CE, FREQ_PIN_RELEASED, SUPPLY_LOW, GATE_AT_TARGET, FREQ_RISE_FAULT;
  logic       SPREAD_FITTED, wake_req, dim_req, sync_req, WAKE, DIM, FREQ_PIN;
  logic [3:0] CH_SHORT, CH_UNUSED, CH_IN_REG, CH_ENABLED;
  logic [9:0] OUT_SENSE_CODE, OVP_LEVEL_CODE;
  logic [7:0] OSC_HALF_PERIOD;
  logic       SUPPLY_ON, GATE_PULL_DOWN, CURRENT_REF_EN, DETECT_ACTIVE, SOFT_START, SWITCH_EN;
  logic       SYNC_MODE, DITHER_EN, OSC_CLAMPED, CLOCK_REPEAT, ERROR_N, LATCHED_OFF;
  int         fail_count, n_checks, cyc;
  boost_startup_and_clock_sequencer #(
    .LATCH_CLR_US(20), .SOFT_START_US(20), .DETECT_US(20)
  ) dut (
    .CLK, .RESET, .CE, .WAKE, .DIM, .FREQ_PIN, .FREQ_PIN_RELEASED, .SUPPLY_LOW,
    .GATE_AT_TARGET, .FREQ_RISE_FAULT, .SPREAD_FITTED, .CH_SHORT, .CH_UNUSED, .CH_IN_REG,
    .OUT_SENSE_CODE, .OVP_LEVEL_CODE, .OSC_HALF_PERIOD, .SUPPLY_ON, .GATE_PULL_DOWN,
    .CURRENT_REF_EN, .DETECT_ACTIVE, .SOFT_START, .SWITCH_EN, .CH_ENABLED, .SYNC_MODE,
    .DITHER_EN, .OSC_CLAMPED, .CLOCK_REPEAT, .ERROR_N, .LATCHED_OFF
  );
  boost_host_model host (
    .CLK, .wake_req, .dim_req, .sync_req, .wake(WAKE), .dim(DIM), .freq_pin(FREQ_PIN)
  );
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  task automatic end_of_test;
    if (fail_count == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  always @(posedge CLK) begin
    cyc++;
    if (cyc == 10000) begin
      fail_count++;
      end_of_test;
    end
  end
  task automatic w(input int k);
    repeat (k) @(posedge CLK);
    #1;
  endtask
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wait_on(ref logic s, input logic lvl, input int lim, output int k);
    k = 0;
    while (s !== lvl && k < lim) begin
      w(1);
      k++;
    end
  endtask
  // Length of the next whole run of the repeat clock at level lvl, in cycles.
  task automatic run_len(input logic lvl, output int len);
    len = 0;
    for (int i = 0; i < 400 && CLOCK_REPEAT !== !lvl; i++) w(1);
    for (int i = 0; i < 400 && CLOCK_REPEAT !== lvl; i++) w(1);
    while (len < 400 && CLOCK_REPEAT === lvl) begin
      len++;
      w(1);
    end
  endtask
  task automatic t_idle;
    int len;
    @(posedge CLK);
    wake_req <= 1'b1;
    w(60);
    cmp(16'(SUPPLY_ON), 16'h0001);
    cmp(16'(GATE_PULL_DOWN), 16'h0000);
    cmp(16'(OSC_CLAMPED), 16'h0000);
    run_len(1'b1, len);
    cmp(16'(len), 16'h000a);
    run_len(1'b0, len);
    cmp(16'(len), 16'h000a);
    @(posedge CLK);
    FREQ_PIN_RELEASED <= 1'b1;
    w(8);
    cmp(16'(GATE_PULL_DOWN), 16'h0001);
    cmp(16'(CURRENT_REF_EN), 16'h0000);
  endtask
  task automatic t_detect;
    int k;
    @(posedge CLK);
    GATE_AT_TARGET <= 1'b1;
    wait_on(CURRENT_REF_EN, 1'b1, 20, k);
    cmp(16'(k <= 6), 16'h0001);
    w(20);
    cmp(16'(DETECT_ACTIVE), 16'h0000);
    @(posedge CLK);
    dim_req <= 1'b1;
    CH_SHORT <= 4'h2;
    w(10);
    cmp(16'(DETECT_ACTIVE), 16'h0001);
    cmp(16'(ERROR_N), 16'h0000);
    w(200);
    cmp(16'(SOFT_START), 16'h0000);
    @(posedge CLK);
    CH_SHORT <= 4'h0;
    w(6);
    cmp(16'(ERROR_N), 16'h0001);
    // The wait starts 213 cycles into the 800-cycle detect phase.
    wait_on(DETECT_ACTIVE, 1'b0, 1000, k);
    cmp(16'(k + 213 >= 760 && k + 213 <= 802), 16'h0001);
    w(1);
    cmp(16'(SOFT_START), 16'h0001);
    cmp(16'(CH_ENABLED), 16'h0007);
    cmp(16'(ERROR_N), 16'h0001);
    cmp(16'(LATCHED_OFF), 16'h0000);
  endtask
  task automatic t_ss_end;
    int k;
    @(posedge CLK);
    CH_IN_REG <= 4'h7;
    wait_on(SOFT_START, 1'b0, 20, k);
    cmp(16'(k <= 6), 16'h0001);
    cmp(16'(SWITCH_EN), 16'h0001);
  endtask
  task automatic t_stuck;
    int k;
    @(posedge CLK);
    FREQ_PIN_RELEASED <= 1'b0;
    CH_IN_REG <= 4'h0;
    w(380);
    cmp(16'(ERROR_N), 16'h0001);
    w(40);
    cmp(16'(ERROR_N), 16'h0000);
    cmp(16'(SWITCH_EN), 16'h0000);
    @(posedge CLK);
    FREQ_PIN_RELEASED <= 1'b1;
    w(8);
    cmp(16'(SOFT_START), 16'h0001);
    cmp(16'(ERROR_N), 16'h0001);
    wait_on(SOFT_START, 1'b0, 1000, k);
    cmp(16'(k >= 740 && k <= 840), 16'h0001);
  endtask
  task automatic t_sync;
    int len;
    @(posedge CLK);
    SPREAD_FITTED <= 1'b1;
    w(6);
    cmp(16'(DITHER_EN), 16'h0001);
    @(posedge CLK);
    sync_req <= 1'b1;
    w(80);
    cmp(16'(SYNC_MODE), 16'h0001);
    cmp(16'(DITHER_EN), 16'h0000);
    run_len(1'b0, len);
    cmp(16'(len), 16'h0006);
    @(posedge CLK);
    sync_req <= 1'b0;
    FREQ_RISE_FAULT <= 1'b1;
    w(150);
    cmp(16'(SYNC_MODE), 16'h0001);
    cmp(16'(OSC_CLAMPED), 16'h0001);
    w(100);
    cmp(16'(SYNC_MODE), 16'h0000);
    cmp(16'(ERROR_N), 16'h0001);
    cmp(16'(SWITCH_EN), 16'h0001);
    cmp(16'(DITHER_EN), 16'h0001);
  endtask
  task automatic t_latch;
    int len;
    @(posedge CLK);
    wake_req <= 1'b0;
    OUT_SENSE_CODE <= 10'h050;
    w(10);
    @(posedge CLK);
    wake_req <= 1'b1;
    w(900);
    cmp(16'(LATCHED_OFF), 16'h0001);
    cmp(16'(SOFT_START), 16'h0000);
    cmp(16'(GATE_PULL_DOWN), 16'h0000);
    @(posedge CLK);
    dim_req <= 1'b0;
    w(600);
    cmp(16'(LATCHED_OFF), 16'h0001);
    run_len(1'b1, len);
    cmp(16'(len), 16'h000a);
    w(300);
    cmp(16'(LATCHED_OFF), 16'h0000);
    @(posedge CLK);
    dim_req <= 1'b1;
    w(900);
    cmp(16'(LATCHED_OFF), 16'h0001);
    @(posedge CLK);
    wake_req <= 1'b0;
    w(900);
    cmp(16'(LATCHED_OFF), 16'h0000);
  endtask
  initial begin
    {RESET, CE, FREQ_PIN_RELEASED, SUPPLY_LOW, GATE_AT_TARGET} = 5'h18;
    {FREQ_RISE_FAULT, SPREAD_FITTED, wake_req, dim_req, sync_req} = 5'h00;
    CH_SHORT = 4'h0;
    CH_UNUSED = 4'h8;
    CH_IN_REG = 4'h0;
    OUT_SENSE_CODE = 10'h064;
    OVP_LEVEL_CODE = 10'h3e8;
    OSC_HALF_PERIOD = 8'h0a;
    fail_count = 0;
    n_checks = 0;
    cyc = 0;
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    t_idle;
    t_detect;
    t_ss_end;
    t_stuck;
    t_sync;
    t_latch;
    end_of_test;
  end
endmodule
